/* File: hdl/psre_exec.sv */
// Pair, stack and accumulator-rotate executor with an AHB-Lite register slave
`timescale 1ns/1ps
module psre_exec (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_rdata,
    output logic o_busy
);
    psre_pkg::psre_core_t r, n;

    // -----------------------------------------------------------------
    // Pair decode
    // -----------------------------------------------------------------
    function automatic logic [15:0] pair_get(psre_pkg::psre_regs_t s, logic [1:0] sel);
        logic [15:0] v;
        case (sel)
            psre_pkg::SEL_BC: v = {s.b, s.c};
            psre_pkg::SEL_DE: v = {s.d, s.e};
            psre_pkg::SEL_HL: v = {s.h, s.l};
            default: v = {psre_pkg::pack_flags(s.flags), s.a};
        endcase
        return v;
    endfunction

    function automatic psre_pkg::psre_regs_t pair_put(psre_pkg::psre_regs_t s, logic [1:0] sel,
                                                      logic [15:0] v);
        psre_pkg::psre_regs_t o;
        o = s;
        case (sel)
            psre_pkg::SEL_BC: {o.b, o.c} = v;
            psre_pkg::SEL_DE: {o.d, o.e} = v;
            psre_pkg::SEL_HL: {o.h, o.l} = v;
            default: begin
                o.flags = psre_pkg::unpack_flags(v[15:8]);
                o.a = v[7:0];
            end
        endcase
        return o;
    endfunction

    // -----------------------------------------------------------------
    // Bus phase and command decode
    // -----------------------------------------------------------------
    logic ahb_take;
    logic busy;
    logic cmd_go;
    logic [7:0] cmd_op;
    logic [15:0] pair_new;
    logic [15:0] pair_cur;
    logic [15:0] hl_val;
    psre_pkg::psre_alu_t alu_mode;
    logic [15:0] alu_sum;
    logic alu_cy;
    logic [7:0] rot_acc;
    logic rot_cy;

    assign ahb_take = i_hsel && i_htrans[1] && i_hready;
    assign busy = (r.state != psre_pkg::PSRE_IDLE);
    // Commands issued while busy are dropped, so software polls busy first
    assign cmd_go = r.pend_wr && (r.pend_addr == psre_pkg::ADDR_CMD) && !busy;
    assign cmd_op = i_hwdata[7:0];
    assign pair_new = pair_get(r.regs, cmd_op[5:4]);
    assign pair_cur = pair_get(r.regs, r.op[5:4]);
    assign hl_val = {r.regs.h, r.regs.l};
    assign alu_mode = (cmd_op[3:0] == psre_pkg::NIB_DADD) ? psre_pkg::PSRE_ALU_ADD :
                      (cmd_op[3] ? psre_pkg::PSRE_ALU_DEC : psre_pkg::PSRE_ALU_INC);

    psre_pair_alu #(.W(16)) u_alu (
        .i_a(pair_new),
        .i_b(hl_val),
        .i_mode(alu_mode),
        .o_sum(alu_sum),
        .o_carry(alu_cy)
    );

    psre_rotate #(.W(8)) u_rot (
        .i_acc(r.regs.a),
        .i_carry(r.regs.flags.carry),
        .i_sel(cmd_op[4:3]),
        .o_acc(rot_acc),
        .o_carry(rot_cy)
    );

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        logic [31:0] rd;
        logic [1:0] sel;
        rd = 32'h0000_0000;
        sel = r.op[5:4];
        n = r;
        n.pend_wr = ahb_take && i_hwrite;
        n.pend_rd = ahb_take && !i_hwrite;
        if (ahb_take) begin
            n.pend_addr = i_haddr[7:0];
        end
        // Reads take one wait state so read data leaves a flop
        if (ahb_take && !i_hwrite) begin
            n.hreadyout = 1'b0;
        end
        if (r.pend_rd) begin
            case (r.pend_addr)
                psre_pkg::ADDR_CMD: rd[7:0] = r.op;
                psre_pkg::ADDR_STATUS: begin
                    rd[psre_pkg::STATUS_BUSY] = busy;
                    rd[psre_pkg::STATUS_ERR] = r.err;
                end
                psre_pkg::ADDR_BC: rd[15:0] = pair_get(r.regs, psre_pkg::SEL_BC);
                psre_pkg::ADDR_DE: rd[15:0] = pair_get(r.regs, psre_pkg::SEL_DE);
                psre_pkg::ADDR_HL: rd[15:0] = hl_val;
                psre_pkg::ADDR_STAT_ACC: rd[15:0] = pair_get(r.regs, psre_pkg::SEL_STAT_ACC);
                psre_pkg::ADDR_SP: rd[15:0] = r.regs.sp;
                default: rd = 32'h0000_0000;
            endcase
            n.hrdata = rd;
            n.hreadyout = 1'b1;
        end

        // Direct register loads, only while no instruction runs
        if (r.pend_wr && !busy) begin
            case (r.pend_addr)
                psre_pkg::ADDR_BC: n.regs = pair_put(r.regs, psre_pkg::SEL_BC, i_hwdata[15:0]);
                psre_pkg::ADDR_DE: n.regs = pair_put(r.regs, psre_pkg::SEL_DE, i_hwdata[15:0]);
                psre_pkg::ADDR_HL: n.regs = pair_put(r.regs, psre_pkg::SEL_HL, i_hwdata[15:0]);
                psre_pkg::ADDR_STAT_ACC: n.regs = pair_put(r.regs, psre_pkg::SEL_STAT_ACC, i_hwdata[15:0]);
                psre_pkg::ADDR_SP: n.regs.sp = i_hwdata[15:0];
                default: n.regs = r.regs;
            endcase
        end

        if (cmd_go) begin
            n.op = cmd_op;
            n.err = 1'b0;
            n.step = psre_pkg::STEP_FIRST;
            if (cmd_op[7:6] == psre_pkg::GRP_HIGH && cmd_op[3:0] == psre_pkg::NIB_SAVE) begin
                n.state = psre_pkg::PSRE_MEM;
                n.kind = psre_pkg::PSRE_K_SAVE;
                n.mem = '{req: 1'b1, we: 1'b1, addr: r.regs.sp - psre_pkg::ONE16,
                          wdata: pair_new[15:8]};
            end else if (cmd_op[7:6] == psre_pkg::GRP_HIGH && cmd_op[3:0] == psre_pkg::NIB_RESTORE) begin
                n.state = psre_pkg::PSRE_MEM;
                n.kind = psre_pkg::PSRE_K_RESTORE;
                n.mem = '{req: 1'b1, we: 1'b0, addr: r.regs.sp, wdata: 8'h00};
            end else if (cmd_op == psre_pkg::OP_STACK_TOP_SWAP) begin
                n.state = psre_pkg::PSRE_MEM;
                n.kind = psre_pkg::PSRE_K_SWAP;
                n.mem = '{req: 1'b1, we: 1'b0, addr: r.regs.sp, wdata: 8'h00};
            end else if (cmd_op[7:6] == psre_pkg::GRP_LOW && cmd_op[3:0] == psre_pkg::NIB_DADD) begin
                n.regs = pair_put(r.regs, psre_pkg::SEL_HL, alu_sum);
                n.regs.flags.carry = alu_cy;
            end else if (cmd_op[7:6] == psre_pkg::GRP_LOW &&
                         (cmd_op[3:0] == psre_pkg::NIB_INC || cmd_op[3:0] == psre_pkg::NIB_DEC)) begin
                // A status-pair target reloads flags from the new high byte
                n.regs = pair_put(r.regs, cmd_op[5:4], alu_sum);
            end else if (cmd_op == psre_pkg::OP_POINTER_SWAP) begin
                {n.regs.h, n.regs.l} = {r.regs.d, r.regs.e};
                {n.regs.d, n.regs.e} = hl_val;
            end else if (cmd_op == psre_pkg::OP_STACK_POINTER_LOAD) begin
                n.regs.sp = hl_val;
            end else if (cmd_op[7:5] == psre_pkg::ROT_HIGH && cmd_op[2:0] == psre_pkg::ROT_LOW) begin
                n.regs.a = rot_acc;
                n.regs.flags.carry = rot_cy;
            end else begin
                n.err = 1'b1;
            end
        end

        // Memory steps advance on each acknowledge of the held request
        if (r.state == psre_pkg::PSRE_MEM && r.mem.req && i_mem_ack) begin
            n.step = r.step + psre_pkg::STEP_ONE;
            unique case (r.kind)
                psre_pkg::PSRE_K_SAVE: begin
                    if (r.step == psre_pkg::STEP_FIRST) begin
                        n.mem.addr = r.regs.sp - psre_pkg::TWO16;
                        n.mem.wdata = pair_cur[7:0];
                    end else begin
                        n.mem.req = 1'b0;
                        n.mem.we = 1'b0;
                        n.regs.sp = r.regs.sp - psre_pkg::TWO16;
                        n.state = psre_pkg::PSRE_IDLE;
                    end
                end
                psre_pkg::PSRE_K_RESTORE: begin
                    if (r.step == psre_pkg::STEP_FIRST) begin
                        n.tmp_lo = i_mem_rdata;
                        n.mem.addr = r.regs.sp + psre_pkg::ONE16;
                    end else begin
                        n.regs = pair_put(r.regs, sel, {i_mem_rdata, r.tmp_lo});
                        n.regs.sp = r.regs.sp + psre_pkg::TWO16;
                        n.mem.req = 1'b0;
                        n.state = psre_pkg::PSRE_IDLE;
                    end
                end
                psre_pkg::PSRE_K_SWAP: begin
                    case (r.step)
                        psre_pkg::STEP_FIRST: begin
                            n.tmp_lo = i_mem_rdata;
                            n.mem.addr = r.regs.sp + psre_pkg::ONE16;
                        end
                        psre_pkg::STEP_SECOND: begin
                            n.tmp_hi = i_mem_rdata;
                            n.mem = '{req: 1'b1, we: 1'b1, addr: r.regs.sp, wdata: r.regs.l};
                        end
                        psre_pkg::STEP_THIRD: begin
                            n.mem.addr = r.regs.sp + psre_pkg::ONE16;
                            n.mem.wdata = r.regs.h;
                        end
                        default: begin
                            n.regs.l = r.tmp_lo;
                            n.regs.h = r.tmp_hi;
                            n.mem.req = 1'b0;
                            n.mem.we = 1'b0;
                            n.state = psre_pkg::PSRE_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            r <= '0;
            r.state <= psre_pkg::PSRE_IDLE;
            r.kind <= psre_pkg::PSRE_K_SAVE;
            r.hreadyout <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    logic hresp_reg;
    logic busy_reg;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            hresp_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            hresp_reg <= 1'b0;
            busy_reg <= (n.state != psre_pkg::PSRE_IDLE);
        end
    end

    assign o_hreadyout = r.hreadyout;
    assign o_hrdata = r.hrdata;
    assign o_hresp = hresp_reg;
    assign o_mem_req = r.mem.req;
    assign o_mem_we = r.mem.we;
    assign o_mem_addr = r.mem.addr;
    assign o_mem_wdata = r.mem.wdata;
    assign o_busy = busy_reg;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    logic [16:0] dad_bc;
    assign dad_bc = {1'b0, r.regs.b, r.regs.c} + {1'b0, hl_val};

    sequence s_save_last;
        r.state == psre_pkg::PSRE_MEM && r.kind == psre_pkg::PSRE_K_SAVE &&
        r.step == psre_pkg::STEP_SECOND && r.mem.req && i_mem_ack;
    endsequence
    sequence s_restore_last;
        r.state == psre_pkg::PSRE_MEM && r.kind == psre_pkg::PSRE_K_RESTORE &&
        r.step == psre_pkg::STEP_SECOND && r.mem.req && i_mem_ack;
    endsequence

    a_save_first_addr: assert property (
        r.state == psre_pkg::PSRE_MEM && r.kind == psre_pkg::PSRE_K_SAVE && r.step == psre_pkg::STEP_FIRST
        |-> r.mem.we && r.mem.addr == r.regs.sp - 16'h0001)
        else $error("save first byte at wrong address");
    a_save_sp_drop: assert property (s_save_last |=> r.regs.sp == $past(r.regs.sp) - 16'h0002 &&
        $stable(r.regs.flags) && !o_mem_req)
        else $error("save did not lower stack pointer by two");
    a_status_byte: assert property (
        r.state == psre_pkg::PSRE_MEM && r.kind == psre_pkg::PSRE_K_SAVE && r.step == psre_pkg::STEP_FIRST &&
        r.op[5:4] == psre_pkg::SEL_STAT_ACC |-> r.mem.wdata[5] == 1'b0 && r.mem.wdata[3] == 1'b0 &&
        r.mem.wdata[1] == 1'b1 && r.mem.wdata[0] == r.regs.flags.carry && r.mem.wdata[7] == r.regs.flags.sign)
        else $error("packed status byte malformed");
    a_restore_addr: assert property (
        r.state == psre_pkg::PSRE_MEM && r.kind == psre_pkg::PSRE_K_RESTORE && r.step == psre_pkg::STEP_SECOND
        |-> !r.mem.we && r.mem.addr == r.regs.sp + 16'h0001)
        else $error("restore second read at wrong address");
    a_restore_flags: assert property (s_restore_last ##0 r.op[5:4] == psre_pkg::SEL_STAT_ACC
        |=> r.regs.flags.carry == $past(i_mem_rdata[0]) && r.regs.flags.zero == $past(i_mem_rdata[6]))
        else $error("status pair restore did not reload flags");
    a_restore_sp_rise: assert property (s_restore_last |=> r.regs.sp == $past(r.regs.sp) + 16'h0002)
        else $error("restore did not raise stack pointer by two");
    a_double_add: assert property (cmd_go && cmd_op == 8'h09
        |=> {r.regs.flags.carry, r.regs.h, r.regs.l} == $past(dad_bc))
        else $error("double add result or carry wrong");
    a_incr_flags: assert property (cmd_go && cmd_op[7:6] == 2'h0 && cmd_op[3:0] == 4'h3 && cmd_op[5:4] != 2'h3
        |=> $stable(r.regs.flags))
        else $error("pair increment touched flags");
    a_sp_load: assert property (cmd_go && cmd_op == 8'hf9 |=> r.regs.sp == $past(hl_val) && $stable(hl_val))
        else $error("stack pointer load wrong");
    a_rotate_left: assert property (cmd_go && cmd_op == 8'h07
        |=> r.regs.a == {$past(r.regs.a[6:0]), $past(r.regs.a[7])} && r.regs.flags.carry == $past(r.regs.a[7]))
        else $error("circular left rotate wrong");
    a_read_wait: assert property (ahb_take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read wait state missing");
endmodule

/* File: hdl/psre_pair_alu.sv */
// Pair arithmetic: add with carry out, increment and decrement
`timescale 1ns/1ps
module psre_pair_alu #(
    parameter int W = 16
) (
    input wire logic [W-1:0] i_a,
    input wire logic [W-1:0] i_b,
    input wire psre_pkg::psre_alu_t i_mode,
    output logic [W-1:0] o_sum,
    output logic o_carry
);
    if (W < 2) begin : g_chk
        $error("psre_pair_alu: W must be at least 2");
    end

    logic [W:0] wide;

    // Sums are one bit wider so the top bit is the carry; the low W bits wrap
    always_comb begin
        unique case (i_mode)
            psre_pkg::PSRE_ALU_ADD: wide = {1'b0, i_a} + {1'b0, i_b};
            psre_pkg::PSRE_ALU_INC: wide = {1'b0, i_a} + {{W{1'b0}}, 1'b1};
            default: wide = {1'b0, i_a} - {{W{1'b0}}, 1'b1};
        endcase
        o_sum = wide[W-1:0];
        o_carry = wide[W];
    end
endmodule

/* File: hdl/psre_pkg.sv */
// Package: map, opcodes, flag layout and carriers of the pair/stack/rotate executor
package psre_pkg;
    // -----------------------------------------------------------------
    // Register map, byte offsets on the bus
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_BC = 8'h08;
    localparam logic [7:0] ADDR_DE = 8'h0c;
    localparam logic [7:0] ADDR_HL = 8'h10;
    localparam logic [7:0] ADDR_STAT_ACC = 8'h14;
    localparam logic [7:0] ADDR_SP = 8'h18;
    localparam int STATUS_BUSY = 0;
    localparam int STATUS_ERR = 1;

    // -----------------------------------------------------------------
    // Opcode fields
    // -----------------------------------------------------------------
    localparam logic [1:0] GRP_LOW = 2'h0;
    localparam logic [1:0] GRP_HIGH = 2'h3;
    localparam logic [3:0] NIB_SAVE = 4'h5;
    localparam logic [3:0] NIB_RESTORE = 4'h1;
    localparam logic [3:0] NIB_DADD = 4'h9;
    localparam logic [3:0] NIB_INC = 4'h3;
    localparam logic [3:0] NIB_DEC = 4'hb;
    localparam logic [7:0] OP_POINTER_SWAP = 8'heb;
    localparam logic [7:0] OP_STACK_TOP_SWAP = 8'he3;
    localparam logic [7:0] OP_STACK_POINTER_LOAD = 8'hf9;
    localparam logic [2:0] ROT_HIGH = 3'h0;
    localparam logic [2:0] ROT_LOW = 3'h7;
    localparam logic [1:0] SEL_BC = 2'h0;
    localparam logic [1:0] SEL_DE = 2'h1;
    localparam logic [1:0] SEL_HL = 2'h2;
    localparam logic [1:0] SEL_STAT_ACC = 2'h3;

    // -----------------------------------------------------------------
    // Packed status byte and constants
    // -----------------------------------------------------------------
    localparam int FB_SIGN = 7;
    localparam int FB_ZERO = 6;
    localparam int FB_AUX = 4;
    localparam int FB_PARITY = 2;
    localparam int FB_ONE = 1;
    localparam int FB_CARRY = 0;
    localparam logic [7:0] FB_BASE = 8'h02;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [15:0] TWO16 = 16'h0002;
    localparam logic [1:0] STEP_FIRST = 2'h0;
    localparam logic [1:0] STEP_ONE = 2'h1;
    localparam logic [1:0] STEP_SECOND = 2'h1;
    localparam logic [1:0] STEP_THIRD = 2'h2;

    typedef struct packed {
        logic sign;
        logic zero;
        logic aux;
        logic parity;
        logic carry;
    } psre_flags_t;

    typedef struct packed {
        logic [7:0] a, b, c, d, e, h, l;
        psre_flags_t flags;
        logic [15:0] sp;
    } psre_regs_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } psre_mem_t;

    typedef enum logic [1:0] {PSRE_IDLE = 2'b01, PSRE_MEM = 2'b10} psre_state_t;
    typedef enum logic [2:0] {
        PSRE_K_SAVE = 3'b001,
        PSRE_K_RESTORE = 3'b010,
        PSRE_K_SWAP = 3'b100
    } psre_kind_t;
    typedef enum logic [1:0] {PSRE_ALU_ADD = 2'h0, PSRE_ALU_INC = 2'h1, PSRE_ALU_DEC = 2'h2} psre_alu_t;

    typedef struct packed {
        psre_state_t state;
        psre_kind_t kind;
        logic [1:0] step;
        logic [7:0] op;
        logic err;
        logic [7:0] tmp_lo;
        logic [7:0] tmp_hi;
        psre_regs_t regs;
        psre_mem_t mem;
        logic pend_wr;
        logic pend_rd;
        logic [7:0] pend_addr;
        logic hreadyout;
        logic [31:0] hrdata;
    } psre_core_t;

    function automatic logic [7:0] pack_flags(psre_flags_t f);
        logic [7:0] v;
        v = FB_BASE;
        v[FB_SIGN] = f.sign;
        v[FB_ZERO] = f.zero;
        v[FB_AUX] = f.aux;
        v[FB_PARITY] = f.parity;
        v[FB_CARRY] = f.carry;
        return v;
    endfunction

    function automatic psre_flags_t unpack_flags(logic [7:0] v);
        psre_flags_t f;
        f.sign = v[FB_SIGN];
        f.zero = v[FB_ZERO];
        f.aux = v[FB_AUX];
        f.parity = v[FB_PARITY];
        f.carry = v[FB_CARRY];
        return f;
    endfunction
endpackage

/* File: hdl/psre_rotate.sv */
// Accumulator rotate unit: circular and through-carry, left and right
`timescale 1ns/1ps
module psre_rotate #(
    parameter int W = 8
) (
    input wire logic [W-1:0] i_acc,
    input wire logic i_carry,
    input wire logic [1:0] i_sel,
    output logic [W-1:0] o_acc,
    output logic o_carry
);
    if (W < 2) begin : g_chk
        $error("psre_rotate: W must be at least 2");
    end

    always_comb begin
        unique case (i_sel)
            2'h0: begin
                o_acc = {i_acc[W-2:0], i_acc[W-1]};
                o_carry = i_acc[W-1];
            end
            2'h1: begin
                o_acc = {i_acc[0], i_acc[W-1:1]};
                o_carry = i_acc[0];
            end
            2'h2: begin
                o_acc = {i_acc[W-2:0], i_carry};
                o_carry = i_acc[W-1];
            end
            2'h3: begin
                o_acc = {i_carry, i_acc[W-1:1]};
                o_carry = i_acc[0];
            end
        endcase
    end
endmodule

/* File: tb/psre_mem_model.sv */
// Behavioural byte-wide stack memory with a random acknowledge delay
`timescale 1ns/1ps
module psre_mem_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic o_ack,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:65535];
    int unsigned wait_cnt = 0;
    initial o_ack = 1'b0;
    initial o_rdata = 8'h00;
    // Idle read data toggles so a stale byte is never taken for an answer
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack) begin
            if (wait_cnt == 0) begin
                o_ack <= 1'b1;
                wait_cnt <= $urandom % 3;
                if (i_we) mem[i_addr] <= i_wdata;
                else o_rdata <= mem[i_addr];
            end else begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the pair, stack and rotate executor
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, hready, mem_req, mem_we, mem_ack, busy, hresp;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [15:0] mem_addr, pr [5] = '{default: 16'h0000};
    logic [7:0] mem_wdata, mem_rdata, em [0:65535];
    logic [7:0] ops [27] = '{8'hc5, 8'hd5, 8'he5, 8'hf5, 8'hc1, 8'hd1, 8'he1, 8'hf1, 8'h09, 8'h19, 8'h29,
        8'h39, 8'h03, 8'h13, 8'h23, 8'h33, 8'h0b, 8'h1b, 8'h2b, 8'h3b, 8'heb, 8'he3, 8'hf9, 8'h07, 8'h0f,
        8'h17, 8'h1f};
    int mismatches = 0, checked = 0;
    psre_exec i_psre_exec (.i_sys_clk(clk), .i_sys_rst(rst), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
        .o_hrdata(hrdata), .o_hresp(hresp), .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
        .o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_busy(busy));
    psre_mem_model i_psre_mem_model (.i_clk(clk), .i_req(mem_req), .i_we(mem_we), .i_addr(mem_addr),
        .i_wdata(mem_wdata), .o_ack(mem_ack), .o_rdata(mem_rdata));
    always #20 clk = ~clk;
    // ------------------------------------------------------------
    // Bus, model and compare tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] fl(input logic [7:0] v);
        return (v & 8'hd5) | 8'h02;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr <= 32'(a);
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic setr(input int i, input logic [15:0] v);
        bus(1'b1, psre_pkg::ADDR_BC + 8'(4 * i), 32'(v));
        pr[i] = (i == 3) ? {fl(v[15:8]), v[7:0]} : v;
    endtask
    task automatic cmp(input logic [15:0] s);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, psre_pkg::ADDR_BC + 8'(4 * i), 32'h0000_0000);
            chk(rd, 32'(pr[i]));
        end
        for (int k = -2; k < 2; k++) chk(32'(i_psre_mem_model.mem[s + 16'(k)]), 32'(em[s + 16'(k)]));
    endtask
    task automatic run(input logic [7:0] op);
        logic [15:0] s;
        logic [16:0] t;
        logic [1:0] p;
        logic [7:0] a;
        s = pr[4];
        p = op[5:4];
        a = pr[3][7:0];
        bus(1'b1, psre_pkg::ADDR_CMD, 32'(op));
        do @(posedge clk); while (busy !== 1'b0 || mem_req !== 1'b0);
        if (op[7:6] == 2'b11 && op[3:0] == 4'h5) begin
            {em[s - 16'h0001], em[s - 16'h0002]} = pr[p];
            pr[4] = s - 16'h0002;
        end else if (op[7:6] == 2'b11 && op[3:0] == 4'h1) begin
            pr[p] = {em[s + 16'h0001], em[s]};
            pr[4] = s + 16'h0002;
        end else if (op[7:6] == 2'b00 && op[3:0] == 4'h9) begin
            t = 17'(pr[2]) + 17'(pr[p]);
            {pr[3][8], pr[2]} = t;
        end else if (op[7:6] == 2'b00 && op[3:0] == 4'h3) pr[p] = pr[p] + 16'h0001;
        else if (op[7:6] == 2'b00 && op[3:0] == 4'hb) pr[p] = pr[p] - 16'h0001;
        else if (op == 8'heb) {pr[1], pr[2]} = {pr[2], pr[1]};
        else if (op == 8'he3) {pr[2], em[s + 16'h0001], em[s]} = {em[s + 16'h0001], em[s], pr[2]};
        else if (op == 8'hf9) pr[4] = pr[2];
        else if (op[4:3] == 2'b00) pr[3][8:0] = {a[7], a[6:0], a[7]};
        else if (op[4:3] == 2'b01) pr[3][8:0] = {a[0], a[0], a[7:1]};
        else if (op[4:3] == 2'b10) pr[3][8:0] = {a[7], a[6:0], pr[3][8]};
        else pr[3][8:0] = {a[0], pr[3][8], a[7:1]};
        pr[3][15:8] = fl(pr[3][15:8]);
        cmp(s);
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hfc54_a74b));
        for (int j = 0; j < 65536; j++) begin
            em[j] = 8'($urandom);
            i_psre_mem_model.mem[j] = em[j];
        end
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pr[3] = 16'h0200;
        cmp(16'h0000);
        $display("Reset values done");
        for (int n = 0; n < 27; n++) begin
            for (int i = 0; i < 5; i++) setr(i, 16'($urandom));
            // Stack pointer near zero makes the stack addresses wrap
            if (n % 3 == 0) setr(4, 16'(n % 2));
            run(ops[n]);
        end
        $display("Directed opcode sweep done");
        repeat (200) run(ops[$urandom % 27]);
        $display("Random opcode stream done");
        bus(1'b1, psre_pkg::ADDR_CMD, 32'h0000_0000);
        bus(1'b0, psre_pkg::ADDR_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        bus(1'b0, 8'h1c, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        run(8'h07);
        bus(1'b0, psre_pkg::ADDR_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(32'(hresp), 32'h0000_0000);
        $display("Refused opcode and unmapped read done");
        // Mid-run reset must bring every register pair and the stack pointer back to their reset values
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pr = '{16'h0000, 16'h0000, 16'h0000, 16'h0200, 16'h0000};
        cmp(16'h0000);
        $display("Mid-run reset done");
        final_report();
    end
    // Bounded by well over the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule
